// ===== hw/ffs_top.sv
// fan fault supervisor with shutdown control and serial management port
// Notes on behaviour
// - fault only after 2.4 s continuous low speed
// - separate 8-bit writable threshold per fan
// - thresholds reset to 500 RPM code
// - low speed drops alert, sets matching fan flag
// - writing clear bit clears both fan flags, releases their alert
// - duty over full scale sets overtemp flag, alert
// - overtemp flag clears when duty drops back
// - shutdown suspends all but the serial port
// - clearing shutdown resumes operation at once
// - leaving shutdown restores defaults except config, thresholds
// - answer only fixed seven-bit address 0011011
// - data stable while clock high, else start/stop
// - start marks beginning of a transfer
// - stop marks end of a transfer; slave has no stop logic, only the next start restarts it
// - receiver pulls data low in acknowledge slot
// - bytes travel most significant bit first
// - device is slave only, never drives clock
// - start, address with direction, acknowledged bytes
// - direction bit one reads; command written first
// - fan faults never stop the drive output
`timescale 1ns/1ps

module ffs_top
  import ffs_pkg::*;
#(
  parameter int unsigned PERSIST_CYCLES = `FFS_PERSIST_MS * `FFS_CLK_KHZ,
  parameter bit          OT_ALERT       = 1'b1
) (
  input  wire logic       clock_i,         // core clock
  input  wire logic       rst_b_i,         // synchronous reset, active low
  input  wire logic       scl_clk_i,       // serial link clock
  input  wire logic       sda_i,           // serial data line level
  output logic            sda_o,           // serial data drive value
  output logic            sda_oe_o,        // serial data drive enable
  input  wire logic [7:0] fan_one_rpm_i,   // measured speed, fan one
  input  wire logic [7:0] fan_two_rpm_i,   // measured speed, fan two
  input  wire logic       duty_over_i,     // demanded duty above full scale
  output logic            fault_alert_b_o, // fault alert, active low
  output logic            pwm_enable_o,    // drive output may pulse
  output logic [7:0]      status_o         // status flags
);

  // ---------------------------------------------------------------------
  // constants and state
  // ---------------------------------------------------------------------
  localparam logic [`FFS_TMR_W-1:0] TLIM = `FFS_TMR_W'(PERSIST_CYCLES - 1);

  ffs_main_state_type s;
  ffs_main_state_type n;
  ffs_link_if         lk ();

  logic wr_evt;
  logic clr_evt;
  logic leave_sd;
  logic sd;
  logic low1;
  logic low2;
  logic set1;
  logic set2;

  // ---------------------------------------------------------------------
  // persistence counter step
  // ---------------------------------------------------------------------
  function automatic logic [`FFS_TMR_W-1:0] next_timer(
    input logic [`FFS_TMR_W-1:0] cnt,
    input logic                  low
  );
    if (!low) begin
      next_timer = '0;
    end else if (cnt == TLIM) begin
      next_timer = cnt;
    end else begin
      next_timer = cnt + `FFS_TMR_W'(1);
    end
  endfunction : next_timer

  // ---------------------------------------------------------------------
  // serial link end
  // ---------------------------------------------------------------------
  ffs_smbus_slave u_slave (
    .scl_clk_i (scl_clk_i),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o),
    .lk        (lk.link)
  );

  assign lk.rd_thr1    = s.thr1;
  assign lk.rd_thr2    = s.thr2;
  assign lk.rd_cfg     = s.cfg;
  assign lk.rd_stat    = status_o;
  assign lk.link_rst_b = s.link_rst_b;

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  always_comb begin
    n            = s;
    n.link_rst_b = 1'b1;
    n.wsync      = {s.wsync[1:0], lk.wr_tog};
    // write toggle passed two stages; command and data held stable by now
    wr_evt       = s.wsync[2] ^ s.wsync[1];
    clr_evt      = 1'b0;
    set1         = 1'b0;
    set2         = 1'b0;
    if (wr_evt) begin
      case (lk.wr_cmd)
        `FFS_CMD_THR1: n.thr1 = lk.wr_data;
        `FFS_CMD_THR2: n.thr2 = lk.wr_data;
        `FFS_CMD_CFG: begin
          n.cfg                = lk.wr_data;
          n.cfg[`FFS_CFG_CLR]  = 1'b0;
          clr_evt              = lk.wr_data[`FFS_CFG_CLR];
        end
        default: ;
      endcase
    end
    sd       = s.cfg[`FFS_CFG_SD];
    leave_sd = s.sd_prev && !sd;
    low1     = fan_one_rpm_i < s.thr1;
    low2     = fan_two_rpm_i < s.thr2;

    if (clr_evt) begin
      n.f1 = 1'b0;
      n.f2 = 1'b0;
    end

    if (leave_sd) begin
      // everything but config and thresholds back to defaults
      n.f1   = 1'b0;
      n.f2   = 1'b0;
      n.ot   = 1'b0;
      n.tmr1 = '0;
      n.tmr2 = '0;
    end else if (sd) begin
      n.tmr1 = '0;
      n.tmr2 = '0;
    end else begin
      n.tmr1 = next_timer(s.tmr1, low1);
      n.tmr2 = next_timer(s.tmr2, low2);
      set1   = low1 && s.tmr1 == TLIM;
      set2   = low2 && s.tmr2 == TLIM;
      // set after clear so a coinciding event is kept
      if (set1) begin
        n.f1 = 1'b1;
      end
      if (set2) begin
        n.f2 = 1'b1;
      end
      n.ot = duty_over_i;
    end

    n.sd_prev = sd;
    n.fault_b = !(n.f1 || n.f2 || (OT_ALERT && n.ot));
    n.pwm_en  = !sd;

    if (!rst_b_i) begin
      n            = '0;
      n.thr1       = `FFS_THR_DEFAULT;
      n.thr2       = `FFS_THR_DEFAULT;
      n.cfg        = `FFS_CFG_RESET;
      n.fault_b    = 1'b1;
      n.pwm_en     = 1'b1;
      n.link_rst_b = 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    s <= n;
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  assign fault_alert_b_o = s.fault_b;
  assign pwm_enable_o    = s.pwm_en;

  always_comb begin
    status_o               = 8'h00;
    status_o[`FFS_STAT_F1] = s.f1;
    status_o[`FFS_STAT_F2] = s.f2;
    status_o[`FFS_STAT_OT] = s.ot;
  end

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  AST_FAULT_PERSIST: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(s.f1) |-> $past(s.tmr1) == TLIM && $past(low1))
    else $error("fan one flag set before persistence elapsed");

  AST_TIMER_RESTART: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s.tmr2 != '0 && fan_two_rpm_i >= s.thr2) |=> s.tmr2 == '0)
    else $error("fan two timer kept counting at good speed");

  AST_THR_WRITE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (wr_evt && lk.wr_cmd == `FFS_CMD_THR2) |=> s.thr2 == $past(lk.wr_data))
    else $error("fan two threshold not written");

  AST_THR_DEFAULT: assert property (@(posedge clock_i)
    $rose(rst_b_i) |-> s.thr1 == `FFS_THR_DEFAULT && s.thr2 == `FFS_THR_DEFAULT)
    else $error("threshold default wrong after reset");

  AST_ALERT_ON_FAN: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $rose(s.f2) |-> !fault_alert_b_o && status_o[`FFS_STAT_F2])
    else $error("fan fault without alert");

  AST_LATCHED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (s.f1 && !clr_evt && !leave_sd) |=> s.f1 && !fault_alert_b_o)
    else $error("fan one flag dropped without clear");

  AST_CLEAR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (clr_evt && !set1 && !set2 && !(OT_ALERT && n.ot)) |=> !s.f1 && !s.f2 && fault_alert_b_o)
    else $error("fault clear ignored");

  AST_OT_FOLLOW: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    (!sd && !leave_sd) |=> s.ot == $past(duty_over_i) && status_o[`FFS_STAT_OT] == s.ot)
    else $error("overtemp flag does not follow demand");

  AST_SHUT_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    sd |=> s.tmr1 == '0 && s.tmr2 == '0 && !pwm_enable_o)
    else $error("timers or drive active in shutdown");

  AST_RESTORE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    leave_sd |=> !s.f1 && !s.f2 && !s.ot && s.thr1 == $past(s.thr1) && pwm_enable_o)
    else $error("shutdown exit did not restore defaults");

endmodule : ffs_top

// ===== inc/ffs_map.svh
// register map, bit positions, reset values and timing constants
`ifndef FFS_MAP_SVH
`define FFS_MAP_SVH

// ---------------------------------------------------------------------
// serial link
// ---------------------------------------------------------------------
`define FFS_SLAVE_ADDR   7'h1b
`define FFS_LAST_BIT     4'h7
`define FFS_ACK_BIT      4'h8

// ---------------------------------------------------------------------
// command bytes
// ---------------------------------------------------------------------
`define FFS_CMD_THR1     8'h02
`define FFS_CMD_THR2     8'h03
`define FFS_CMD_CFG      8'h04
`define FFS_CMD_STAT     8'h05

// ---------------------------------------------------------------------
// fields and reset values
// ---------------------------------------------------------------------
`define FFS_CFG_SD       0
`define FFS_CFG_CLR      7
`define FFS_STAT_F1      0
`define FFS_STAT_F2      1
`define FFS_STAT_OT      5
`define FFS_CFG_RESET    8'h0a
`define FFS_THR_DEFAULT  8'h0a

// ---------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------
`define FFS_PERSIST_MS   2400
`define FFS_CLK_KHZ      10000
`define FFS_TMR_W        25

`endif

// ===== inc/ffs_pkg.sv
// types shared by the fan supervisor modules
`include "ffs_map.svh"

package ffs_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR,
    PH_CMD,
    PH_WDATA,
    PH_RDATA
  } ffs_phase_type;

  typedef struct packed {
    ffs_phase_type phase;
    logic [3:0]    bits;
    logic [7:0]    shreg;
    logic [7:0]    cmd;
    logic [7:0]    wr_data;
    logic          wr_tog;
    logic          st_ack;
    logic          ack_en;
  } ffs_link_state_type;

  typedef struct packed {
    logic [7:0]            thr1;
    logic [7:0]            thr2;
    logic [7:0]            cfg;
    logic                  f1;
    logic                  f2;
    logic                  ot;
    logic [`FFS_TMR_W-1:0] tmr1;
    logic [`FFS_TMR_W-1:0] tmr2;
    logic [2:0]            wsync;
    logic                  sd_prev;
    logic                  fault_b;
    logic                  pwm_en;
    logic                  link_rst_b;
  } ffs_main_state_type;

endpackage : ffs_pkg

// ===== inc/ffs_link_if.sv
// carrier between the supervisor core and the serial link end
`timescale 1ns/1ps

interface ffs_link_if;
  logic [7:0] rd_thr1;
  logic [7:0] rd_thr2;
  logic [7:0] rd_cfg;
  logic [7:0] rd_stat;
  logic [7:0] wr_cmd;
  logic [7:0] wr_data;
  logic       wr_tog;
  logic       link_rst_b;

  modport core (output rd_thr1, rd_thr2, rd_cfg, rd_stat, link_rst_b,
                input  wr_cmd, wr_data, wr_tog);
  modport link (input  rd_thr1, rd_thr2, rd_cfg, rd_stat, link_rst_b,
                output wr_cmd, wr_data, wr_tog);
endinterface : ffs_link_if

// ===== hw/ffs_smbus_slave.sv
// serial management slave, clocked by the link clock
`timescale 1ns/1ps

module ffs_smbus_slave
  import ffs_pkg::*;
(
  input  wire logic scl_clk_i,  // link clock from the master
  input  wire logic sda_i,      // data line level
  output logic      sda_o,      // data line drive value
  output logic      sda_oe_o,   // high while pulling data low
  ffs_link_if.link  lk          // core side
);

  ffs_link_state_type s;
  ffs_link_state_type n;
  logic               st_tog;
  logic               st_new;
  logic [7:0]         rd_mux;

  // ---------------------------------------------------------------------
  // start capture: data falling while clock high
  // ---------------------------------------------------------------------
  always_ff @(negedge sda_i or negedge lk.link_rst_b) begin
    if (!lk.link_rst_b) begin
      st_tog <= 1'b0;
    end else if (scl_clk_i) begin
      st_tog <= ~st_tog;
    end
  end

  always_comb begin
    case (s.cmd)
      `FFS_CMD_THR1: rd_mux = lk.rd_thr1;
      `FFS_CMD_THR2: rd_mux = lk.rd_thr2;
      `FFS_CMD_CFG:  rd_mux = lk.rd_cfg;
      `FFS_CMD_STAT: rd_mux = lk.rd_stat;
      default:       rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------------
  // bit engine on rising clock
  // ---------------------------------------------------------------------
  always_comb begin
    n      = s;
    st_new = st_tog ^ s.st_ack;
    if (st_new) begin
      // new frame restarts the engine, so a stop needs no logic
      n.st_ack = st_tog;
      n.phase  = PH_ADDR;
      n.bits   = 4'h1;
      n.shreg  = {7'h00, sda_i};
      n.ack_en = 1'b0;
    end else if (s.phase != PH_IDLE) begin
      if (s.bits != `FFS_ACK_BIT) begin
        n.shreg = {s.shreg[6:0], sda_i};
        n.bits  = s.bits + 4'h1;
        if (s.bits == `FFS_LAST_BIT) begin
          case (s.phase)
            PH_ADDR:  n.ack_en = (s.shreg[6:0] == `FFS_SLAVE_ADDR);
            PH_CMD:   n.ack_en = 1'b1;
            PH_WDATA: n.ack_en = 1'b1;
            default:  n.ack_en = 1'b0;
          endcase
        end
      end else begin
        n.bits = 4'h0;
        case (s.phase)
          PH_ADDR: begin
            if (!s.ack_en) begin
              n.phase = PH_IDLE;
            end else if (s.shreg[0]) begin
              n.phase = PH_RDATA;
              n.shreg = rd_mux;
            end else begin
              n.phase = PH_CMD;
            end
          end
          PH_CMD: begin
            n.cmd   = s.shreg;
            n.phase = PH_WDATA;
          end
          PH_WDATA: begin
            n.wr_data = s.shreg;
            n.wr_tog  = ~s.wr_tog;
          end
          PH_RDATA: begin
            if (sda_i) begin
              n.phase = PH_IDLE;
            end else begin
              n.shreg = rd_mux;
            end
          end
          default: n.phase = PH_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge scl_clk_i or negedge lk.link_rst_b) begin
    if (!lk.link_rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------------
  // data drive changes only while the clock is low
  // ---------------------------------------------------------------------
  always_ff @(negedge scl_clk_i or negedge lk.link_rst_b) begin
    if (!lk.link_rst_b) begin
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else begin
      sda_o    <= 1'b0;
      sda_oe_o <= (s.bits == `FFS_ACK_BIT && s.ack_en && s.phase != PH_RDATA) ||
                  (s.phase == PH_RDATA && s.bits != `FFS_ACK_BIT && !s.shreg[7]);
    end
  end

  assign lk.wr_cmd  = s.cmd;
  assign lk.wr_data = s.wr_data;
  assign lk.wr_tog  = s.wr_tog;

  AST_ADDR_MISS_NO_ACK: assert property (@(posedge scl_clk_i) disable iff (!lk.link_rst_b)
    (!st_new && s.phase == PH_ADDR && s.bits == `FFS_LAST_BIT &&
     s.shreg[6:0] != `FFS_SLAVE_ADDR) |=> !s.ack_en)
    else $error("foreign address acknowledged");

endmodule : ffs_smbus_slave

// ===== bench/ffs_host_model.sv
// behavioural serial management master at the far side of the link
`timescale 1ns/1ps
`include "ffs_map.svh"

module ffs_host_model (
  output logic      scl_o,      // link clock, stands high while idle
  output logic      pull_low_o, // master pulls the data line low
  input  wire logic sda_i       // resolved data line level
);
  time        half = 16;
  logic       last_ack;
  logic [7:0] last_rd;
  event       ack_ev;
  event       rd_ev;

  initial begin
    scl_o      = 1'b1;
    pull_low_o = 1'b0;
  end

  // data moves only while the clock is low
  task automatic put_bit(input logic b);
    pull_low_o = ~b;
    #half scl_o = 1'b1;
    #half scl_o = 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    pull_low_o = 1'b0;
    #half scl_o = 1'b1;
    b = sda_i;
    #half scl_o = 1'b0;
  endtask : get_bit

  task automatic start_cond();
    pull_low_o = 1'b0;
    #half scl_o = 1'b1;
    #half pull_low_o = 1'b1;
    #half scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    pull_low_o = 1'b1;
    #half scl_o = 1'b1;
    #half pull_low_o = 1'b0;
    #half;
  endtask : stop_cond

  task automatic send_byte(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(a);
    last_ack = ~a;
    -> ack_ev;
  endtask : send_byte

  task automatic recv_byte();
    logic [7:0] b;
    logic       x;
    for (int i = 0; i < 8; i++) begin
      get_bit(x);
      b = {b[6:0], x};
    end
    put_bit(1'b1); // nack ends the read
    last_rd = b;
    -> rd_ev;
  endtask : recv_byte

  task automatic write_reg(input logic [6:0] adr, input logic [7:0] cmd, input logic [7:0] dat);
    start_cond();
    send_byte({adr, 1'b0});
    if (last_ack) begin
      send_byte(cmd);
      send_byte(dat);
    end
    stop_cond();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] cmd);
    start_cond();
    send_byte({`FFS_SLAVE_ADDR, 1'b0});
    send_byte(cmd);
    start_cond();
    send_byte({`FFS_SLAVE_ADDR, 1'b1});
    recv_byte();
    stop_cond();
  endtask : read_reg
endmodule : ffs_host_model

// ===== bench/testbench.sv
// self-checking bench for the fan fault supervisor
`timescale 1ns/1ps
`include "ffs_map.svh"

module testbench;
  localparam int P = 16;
  logic       clock_i;
  logic       rst_b_i;
  logic       scl;
  logic       host_low;
  logic       sda_oe;
  logic       sda_drv;
  wire        sda;
  logic [7:0] rpm1;
  logic [7:0] rpm2;
  logic [7:0] status;
  logic       duty_over;
  logic       alert_b;
  logic       pwm_en;
  integer     miscompares = 0;
  integer     compares    = 0;
  integer     seed        = 32'h19d72b4a;
  logic [7:0] thr1;
  logic [7:0] thr2;
  logic       exp_ack[$];
  logic [7:0] exp_rd[$];
  logic [9:0] exp_out[$];
  logic [6:0] bad_adr[3] = '{7'h1a, 7'h6c, 7'h5b};
  event       out_ev;

  assign sda = ~((sda_oe & ~sda_drv) | host_low);

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  ffs_top #(.PERSIST_CYCLES(P), .OT_ALERT(1'b1)) DUT (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .scl_clk_i(scl), .sda_i(sda),
    .sda_o(sda_drv), .sda_oe_o(sda_oe), .fan_one_rpm_i(rpm1),
    .fan_two_rpm_i(rpm2), .duty_over_i(duty_over), .fault_alert_b_o(alert_b),
    .pwm_enable_o(pwm_en), .status_o(status)
  );

  ffs_host_model host (.scl_o(scl), .pull_low_o(host_low), .sda_i(sda));

  // ---------------------------------------------------------------
  // comparison and reporting
  // ---------------------------------------------------------------
  task automatic fail(input string msg);
    miscompares++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmp_ack(input logic got, input logic exp);
    compares++;
    if (got !== exp) fail($sformatf("ack %b, expected %b", got, exp));
  endtask : cmp_ack

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
  endtask : cmp_rd

  task automatic cmp_out(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp) fail($sformatf("alert/pwm/status %h, expected %h", got, exp));
  endtask : cmp_out

  task automatic report_and_stop();
    if (exp_ack.size() + exp_rd.size() + exp_out.size() != 0) fail("results missing");
    $display("compares %0d, miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  always @(host.ack_ev) cmp_ack(host.last_ack, exp_ack.pop_front());
  always @(host.rd_ev) cmp_rd(host.last_rd, exp_rd.pop_front());
  always @(out_ev) cmp_out({alert_b, pwm_en, status}, exp_out.pop_front());
  always @(sda_oe) if (scl === 1'b1 && rst_b_i === 1'b1) fail("data drive moved while clock high");

  initial begin
    #3_000_000;
    fail("watchdog expired");
    report_and_stop();
  end

  // ---------------------------------------------------------------
  // stimulus helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    repeat (3) exp_ack.push_back(1'b1);
    #13;
    host.write_reg(`FFS_SLAVE_ADDR, cmd, dat);
    repeat (8) @(posedge clock_i);
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
    repeat (3) exp_ack.push_back(1'b1);
    exp_rd.push_back(exp);
    #13;
    host.read_reg(cmd);
  endtask : rd

  task automatic chk(input logic alert, input logic pwm, input logic [7:0] st);
    @(posedge clock_i);
    #1;
    exp_out.push_back({alert, pwm, st});
    -> out_ev;
  endtask : chk

  task automatic hold(input logic [7:0] r1, input logic [7:0] r2, input int n);
    @(posedge clock_i);
    rpm1 <= r1;
    rpm2 <= r2;
    repeat (n - 1) @(posedge clock_i);
  endtask : hold

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    rst_b_i   = 1'b0;
    rpm1      = 8'hff;
    rpm2      = 8'hff;
    duty_over = 1'b0;
    repeat (5) @(posedge clock_i);
    rst_b_i <= 1'b1;
    chk(1'b1, 1'b1, 8'h00);
    repeat (3) @(posedge clock_i);
    for (int i = 0; i < 3; i++) begin
      exp_ack.push_back(1'b0);
      host.write_reg(bad_adr[i], `FFS_CMD_THR1, 8'h55);
    end
    rd(`FFS_CMD_THR1, `FFS_THR_DEFAULT);
    rd(`FFS_CMD_THR2, `FFS_THR_DEFAULT);
    rd(`FFS_CMD_CFG, `FFS_CFG_RESET);
    rd(`FFS_CMD_STAT, 8'h00);
    thr1 = 8'h20 + {3'h0, 5'($random(seed))};
    thr2 = 8'h40 + {3'h0, 5'($random(seed))};
    wr(`FFS_CMD_THR1, thr1);
    wr(`FFS_CMD_THR2, thr2);
    rd(`FFS_CMD_THR1, thr1);
    host.half = 40;
    rd(`FFS_CMD_THR2, thr2);
    host.half = 16;
    hold(thr1 - 8'h01, 8'hff, P - 2);
    hold(thr1, 8'hff, 4);
    hold(thr1 - 8'h01, 8'hff, P - 2);
    hold(8'hff, thr2, 4);
    chk(1'b1, 1'b1, 8'h00);
    hold(thr1 - 8'h01 - {4'h0, 4'($random(seed))}, 8'hff, P + 4);
    chk(1'b0, 1'b1, 8'h01);
    hold(8'hff, 8'hff, 40);
    chk(1'b0, 1'b1, 8'h01);
    rd(`FFS_CMD_STAT, 8'h01);
    wr(`FFS_CMD_CFG, `FFS_CFG_RESET | 8'h80);
    chk(1'b1, 1'b1, 8'h00);
    rd(`FFS_CMD_CFG, `FFS_CFG_RESET);
    hold(8'hff, thr2 - 8'h01 - {4'h0, 4'($random(seed))}, P + 4);
    chk(1'b0, 1'b1, 8'h02);
    hold(8'hff, 8'hff, 2);
    wr(`FFS_CMD_CFG, `FFS_CFG_RESET | 8'h80);
    @(posedge clock_i);
    duty_over <= 1'b1;
    repeat (3) @(posedge clock_i);
    chk(1'b0, 1'b1, 8'h20);
    rd(`FFS_CMD_STAT, 8'h20);
    @(posedge clock_i);
    duty_over <= 1'b0;
    repeat (3) @(posedge clock_i);
    chk(1'b1, 1'b1, 8'h00);
    hold(8'h00, 8'hff, P + 4);
    wr(`FFS_CMD_CFG, `FFS_CFG_RESET | 8'h01);
    chk(1'b0, 1'b0, 8'h01);
    @(posedge clock_i);
    duty_over <= 1'b1;
    hold(8'h00, 8'h00, P + 4);
    chk(1'b0, 1'b0, 8'h01);
    rd(`FFS_CMD_CFG, `FFS_CFG_RESET | 8'h01);
    @(posedge clock_i);
    duty_over <= 1'b0;
    hold(8'hff, 8'hff, 4);
    wr(`FFS_CMD_CFG, `FFS_CFG_RESET);
    chk(1'b1, 1'b1, 8'h00);
    rd(`FFS_CMD_THR1, thr1);
    rd(`FFS_CMD_THR2, thr2);
    rd(`FFS_CMD_CFG, `FFS_CFG_RESET);
    hold(8'hff, 8'h00, P + 4);
    chk(1'b0, 1'b1, 8'h02);
    repeat (4) @(posedge clock_i);
    report_and_stop();
  end
endmodule : testbench
